/* File: twh_top.sv */
// Two-wire host handshake unit: AXI4-Lite registers, completion flag,
// status posting and a simple master engine for START, byte and STOP.
// Assumes open-drain pins resolved outside; pins are asynchronous.
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
module twh_top
	import twh_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic awvalid,
	output logic awready,
	input wire logic [twh_pkg::TWH_ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [twh_pkg::TWH_ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Serial pins
	input wire logic scl_i,
	input wire logic sda_i,
	output twh_pkg::twh_pin_s scl_pin,
	output twh_pkg::twh_pin_s sda_pin,
	// Interrupt request
	output logic irq
);
	import twh_pkg::*;

	logic [1:0] pins_s, ph_r;
	logic [7:0] ctrl_r, status_r, code_r, cnt_r;
	logic [7:0] shift_data_reg, cpu_flags_reg;
	twh_state_e state_r;
	logic [3:0] bit_r;
	logic flag_r, rstart_r, event_r, busy_r, samp_r;
	logic aw_got_r, w_got_r;
	logic [TWH_ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic wr_do, ctrl_wr, launch, tick;
	logic scl_low_nxt, sda_low_nxt;

	twh_sync u_sync (.aclk(aclk), .aresetn(aresetn), .d({scl_i, sda_i}),
		.q(pins_s));

	function automatic logic addr_hit(input logic [TWH_ADDR_W-1:0] a,
		input logic [TWH_ADDR_W-1:0] r);
		addr_hit = (a == r);
	endfunction : addr_hit

	// Write channel: address and data are taken in either order.
	assign wr_do = aw_got_r && w_got_r && !bvalid;
	assign ctrl_wr = wr_do && addr_hit(awaddr_r, TWH_ADDR_CTRL) && wstrb_r[0];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready <= 1'b1;
			wready <= 1'b1;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			bvalid <= 1'b0;
			bresp <= TWH_RESP_OKAY;
		end
		else
		begin
			if (awvalid && awready)
			begin
				awaddr_r <= awaddr;
				aw_got_r <= 1'b1;
				awready <= 1'b0;
			end
			if (wvalid && wready)
			begin
				wdata_r <= wdata;
				wstrb_r <= wstrb;
				w_got_r <= 1'b1;
				wready <= 1'b0;
			end
			if (wr_do)
			begin
				bvalid <= 1'b1;
				if (addr_hit(awaddr_r, TWH_ADDR_CTRL) ||
					addr_hit(awaddr_r, TWH_ADDR_DATA) ||
					addr_hit(awaddr_r, TWH_ADDR_CPU) ||
					addr_hit(awaddr_r, TWH_ADDR_STATUS))
					bresp <= TWH_RESP_OKAY;
				else
					bresp <= TWH_RESP_SLVERR;
			end
			if (bvalid && bready)
			begin
				bvalid <= 1'b0;
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// Control register; the flag bit itself is not stored here.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl_r <= TWH_ZERO8;
		else if (ctrl_wr)
			ctrl_r <= wdata_r[7:0];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cpu_flags_reg <= TWH_ZERO8;
		else if (wr_do && addr_hit(awaddr_r, TWH_ADDR_CPU) && wstrb_r[0])
			cpu_flags_reg <= wdata_r[7:0];
	end

	// Software loads the shift register while the flag is set; writes
	// during a transfer are dropped so the byte on the wire stays intact.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			shift_data_reg <= TWH_ZERO8;
		else if (wr_do && addr_hit(awaddr_r, TWH_ADDR_DATA) && wstrb_r[0] &&
			!busy_r)
			shift_data_reg <= wdata_r[7:0];
		else if (state_r == TWH_BITS && tick && ph_r == TWH_PH_LAST &&
			bit_r != TWH_BIT_LAST)
			shift_data_reg <= {shift_data_reg[6:0], samp_r};
	end

	// Completion flag: a hardware event wins over a same-cycle clear.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			flag_r <= 1'b0;
		else if (event_r)
			flag_r <= 1'b1;
		else if (ctrl_wr && wdata_r[TWH_CTL_FLAG])
			flag_r <= 1'b0;
	end

	// Status follows the flag one cycle later; otherwise the idle code.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			status_r <= TWH_ST_NONE;
		else if (flag_r)
			status_r <= code_r;
		else
			status_r <= TWH_ST_NONE;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq <= 1'b0;
		else
			irq <= flag_r && ctrl_r[TWH_CTL_IRQ_EN] &&
				cpu_flags_reg[TWH_CPU_GIE];
	end

	// Read channel.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= TWH_RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rresp <= TWH_RESP_OKAY;
			rdata <= '0;
			if (addr_hit(araddr, TWH_ADDR_CTRL))
				rdata[7:0] <= {flag_r, ctrl_r[6:0]};
			else if (addr_hit(araddr, TWH_ADDR_STATUS))
				rdata[7:0] <= status_r;
			else if (addr_hit(araddr, TWH_ADDR_DATA))
				rdata[7:0] <= shift_data_reg;
			else if (addr_hit(araddr, TWH_ADDR_CPU))
				rdata[7:0] <= cpu_flags_reg;
			else
				rresp <= TWH_RESP_SLVERR;
		end
		else if (rvalid && rready)
		begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// An operation launches only from a control write that clears the flag
	// while the unit is enabled and idle.
	assign launch = ctrl_wr && wdata_r[TWH_CTL_FLAG] &&
		wdata_r[TWH_CTL_ENABLE] && !busy_r && !event_r;
	assign tick = (cnt_r == TWH_CNT_ONE);

	// Engine: four quarter phases a bit, clock high in phases 1 and 2. Slaves
	// that stretch the clock are not waited for; this keeps the engine simple.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r <= TWH_IDLE;
			cnt_r <= TWH_QUARTER_CYC;
			ph_r <= '0;
			bit_r <= TWH_BIT_ZERO;
			rstart_r <= 1'b0;
			event_r <= 1'b0;
			busy_r <= 1'b0;
			samp_r <= 1'b1;
			code_r <= TWH_ST_NONE;
		end
		else
		begin
			event_r <= 1'b0;
			cnt_r <= tick ? TWH_QUARTER_CYC : cnt_r - TWH_CNT_ONE;
			case (state_r)
				TWH_IDLE:
				begin
					cnt_r <= TWH_QUARTER_CYC;
					ph_r <= '0;
					if (launch)
					begin
						busy_r <= 1'b1;
						bit_r <= TWH_BIT_ZERO;
						if (wdata_r[TWH_CTL_START])
							state_r <= TWH_START;
						else if (wdata_r[TWH_CTL_STOP])
							state_r <= TWH_STOP;
						else
							state_r <= TWH_BITS;
					end
				end
				TWH_START:
				begin
					if (tick)
					begin
						ph_r <= ph_r + 2'h1;
						if (ph_r == TWH_PH_LAST)
						begin
							code_r <= rstart_r ? TWH_ST_RSTART : TWH_ST_START;
							rstart_r <= 1'b1;
							event_r <= 1'b1;
							state_r <= TWH_WAIT;
						end
					end
				end
				TWH_BITS:
				begin
					if (tick)
					begin
						ph_r <= ph_r + 2'h1;
						if (ph_r == TWH_PH_SAMPLE)
							samp_r <= pins_s[0];
						if (ph_r == TWH_PH_LAST)
						begin
							bit_r <= bit_r + 4'h1;
							if (bit_r == TWH_BIT_LAST)
							begin
								// Acknowledge is sda low at the end of the high phase.
								if (code_r == TWH_ST_START ||
									code_r == TWH_ST_RSTART)
									code_r <= samp_r ? TWH_ST_ADDR_NACK
										: TWH_ST_ADDR_ACK;
								else
									code_r <= samp_r ? TWH_ST_DATA_NACK
										: TWH_ST_DATA_ACK;
								event_r <= 1'b1;
								state_r <= TWH_WAIT;
							end
						end
					end
				end
				TWH_STOP:
				begin
					if (tick)
					begin
						ph_r <= ph_r + 2'h1;
						if (ph_r == TWH_PH_LAST)
						begin
							rstart_r <= 1'b0;
							busy_r <= 1'b0;
							code_r <= TWH_ST_NONE;
							state_r <= TWH_IDLE;
						end
					end
				end
				TWH_WAIT:
				begin
					busy_r <= 1'b0;
					state_r <= TWH_IDLE;
				end
				default: state_r <= TWH_IDLE;
			endcase
		end
	end

	// Pin drive, decided from the engine phase.
	always_comb
	begin
		case (state_r)
			TWH_START:
			begin
				// A repeated start first lets sda up while the clock is low.
				scl_low_nxt = (ph_r == TWH_PH_LAST) ||
					(rstart_r && ph_r == 2'h0);
				sda_low_nxt = ph_r[1];
			end
			TWH_BITS:
			begin
				scl_low_nxt = (ph_r == 2'h0) || (ph_r == TWH_PH_LAST);
				sda_low_nxt = (bit_r != TWH_BIT_LAST) && !shift_data_reg[7];
			end
			TWH_STOP:
			begin
				scl_low_nxt = (ph_r == 2'h0);
				sda_low_nxt = !ph_r[1];
			end
			default:
			begin
				scl_low_nxt = rstart_r;
				sda_low_nxt = rstart_r;
			end
		endcase
		if (flag_r || event_r)
			scl_low_nxt = 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			scl_pin <= '0;
			sda_pin <= '0;
		end
		else
		begin
			scl_pin.o <= 1'b0;
			scl_pin.oe <= scl_low_nxt;
			sda_pin.o <= 1'b0;
			sda_pin.oe <= sda_low_nxt;
		end
	end
endmodule : twh_top

/* File: twh_pkg.sv */
// Package for the two-wire host handshake unit: register map, control
// fields, status codes, bus timing and carrier types.
// Assumes a 10 MHz clock and an AXI4-Lite register bus with 32-bit data.
package twh_pkg;
	localparam logic [3:0] TWH_ADDR_CTRL = 4'h0;
	localparam logic [3:0] TWH_ADDR_STATUS = 4'h4;
	localparam logic [3:0] TWH_ADDR_DATA = 4'h8;
	localparam logic [3:0] TWH_ADDR_CPU = 4'hC;
	localparam int TWH_ADDR_W = 4;

	// Control register bit positions, and the GIE bit of the CPU register.
	localparam int TWH_CTL_IRQ_EN = 0;
	localparam int TWH_CTL_ENABLE = 2;
	localparam int TWH_CTL_STOP = 4;
	localparam int TWH_CTL_START = 5;
	localparam int TWH_CTL_ACK_EN = 6;
	localparam int TWH_CTL_FLAG = 7;
	localparam int TWH_CPU_GIE = 7;

	localparam logic [7:0] TWH_ST_START = 8'h08;
	localparam logic [7:0] TWH_ST_RSTART = 8'h10;
	localparam logic [7:0] TWH_ST_ADDR_ACK = 8'h18;
	localparam logic [7:0] TWH_ST_ADDR_NACK = 8'h20;
	localparam logic [7:0] TWH_ST_DATA_ACK = 8'h28;
	localparam logic [7:0] TWH_ST_DATA_NACK = 8'h30;
	localparam logic [7:0] TWH_ST_NONE = 8'hF8;
	localparam logic [7:0] TWH_ZERO8 = 8'h00;

	localparam logic [1:0] TWH_RESP_OKAY = 2'h0;
	localparam logic [1:0] TWH_RESP_SLVERR = 2'h2;

	// Bus timing: one serial quarter bit in ns, rounded down to cycles.
	localparam int TWH_CLK_NS = 100;
	localparam int TWH_QUARTER_NS = 2500;
	localparam int TWH_QUARTER_CYC_I = TWH_QUARTER_NS / TWH_CLK_NS;
	localparam logic [7:0] TWH_QUARTER_CYC = 8'(TWH_QUARTER_CYC_I);
	localparam logic [7:0] TWH_CNT_ONE = 8'h01;
	localparam logic [3:0] TWH_BIT_LAST = 4'h8;
	localparam logic [3:0] TWH_BIT_ZERO = 4'h0;
	localparam logic [1:0] TWH_PH_LAST = 2'h3;
	localparam logic [1:0] TWH_PH_SAMPLE = 2'h2;

	typedef enum logic [2:0] {
		TWH_IDLE = 3'b000,
		TWH_START = 3'b001,
		TWH_BITS = 3'b010,
		TWH_STOP = 3'b011,
		TWH_WAIT = 3'b100
	} twh_state_e;

	// Open-drain pin, output enable high while pulling low.
	typedef struct packed {
		logic o;
		logic oe;
	} twh_pin_s;
endpackage : twh_pkg

/* File: twh_sync.sv */
// Two-flop synchroniser for the serial pins.
// Assumes inputs asynchronous to aclk.
`timescale 1ns/100ps
module twh_sync
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Data
	input wire logic [1:0] d,
	output logic [1:0] q
);
	logic [1:0] meta_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_r <= 2'h3;
			q <= 2'h3;
		end
		else
		begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : twh_sync

/* File: twh_top_props.sv */
// Port-level checks for the two-wire host handshake unit.
// Assumes it is bound to twh_top and sees only that module's ports.
`timescale 1ns/100ps
module twh_top_props
	import twh_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	// Serial pins and interrupt
	input wire twh_pkg::twh_pin_s scl_pin,
	input wire twh_pkg::twh_pin_s sda_pin,
	input wire logic irq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_write_lat: assert property (awvalid && awready && wvalid && wready
		|-> ##2 bvalid) else $error("write answer late");
	a_b_hold: assert property (bvalid && !bready |=> bvalid)
		else $error("write answer dropped");
	a_b_busy: assert property (bvalid |-> !awready && !wready)
		else $error("ready while answer pending");
	a_read_lat: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer changed");
	a_err_zero: assert property (rvalid && rresp == TWH_RESP_SLVERR
		|-> rdata == 32'h0) else $error("error read not zero");
	// Checked one cycle in, since the request output lags the flag.
	a_irq_scl: assert property ($past(irq) && irq |-> scl_pin.oe)
		else $error("clock line released while flag set");
	a_pins_low: assert property (!scl_pin.o && !sda_pin.o)
		else $error("open-drain pin driven high");

	cover property ($rose(irq));
	cover property (rvalid && rresp == TWH_RESP_SLVERR);
	cover property ($fell(scl_pin.oe));
endmodule : twh_top_props

/* File: twh_slave.sv */
// Behavioural bus slave: shifts in each byte and answers on the ninth bit.
// Assumes resolved line levels with pull-ups; it only ever pulls data low.
`timescale 1ns/100ps
module twh_slave
(
	// Resolved lines
	input wire logic scl,
	input wire logic sda,
	// Answer control and capture
	input wire logic nack,
	output logic sda_oe,
	output logic [7:0] last
);
	logic [3:0] cnt = 4'h0;
	logic [7:0] sh = 8'h00;
	initial sda_oe = 1'b0;
	initial last = 8'h00;
	// A START restarts the count, so a stray clock pulse cannot skew framing.
	always @(negedge sda)
		if (scl)
			cnt <= 4'h0;
	always @(posedge scl)
	begin
		cnt <= cnt + 4'h1;
		sh <= {sh[6:0], sda};
	end
	always @(negedge scl)
		if (cnt == 4'h8)
		begin
			sda_oe <= !nack;
			last <= sh;
		end
		else if (cnt == 4'h9)
		begin
			sda_oe <= 1'b0;
			cnt <= 4'h0;
		end
endmodule : twh_slave

/* File: test_two_wire_host_handshake.sv */
// Self-checking bench: register bus master, slave model and checker.
// Assumes a 10 MHz clock and byte transfers of about 900 cycles each.
`timescale 1ns/100ps
module test_two_wire_host_handshake;
	import twh_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, nack = 1'b0, n;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
	logic [31:0] wdata = 32'h0, v, d = 32'hE0E5;
	logic awready, wready, bvalid, arready, rvalid, irq, s_oe;
	logic [1:0] bresp, rresp, rr;
	logic [31:0] rdata;
	logic [7:0] got;
	twh_pin_s scl_pin, sda_pin;
	wire scl = !scl_pin.oe;
	wire sda = !(sda_pin.oe || s_oe);
	int fail_count = 0, n_compared = 0, cyc = 0, t, k;

	twh_top dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
		.wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
		.arready, .araddr, .rvalid, .rready, .rdata, .rresp, .scl_i(scl),
		.sda_i(sda), .scl_pin, .sda_pin, .irq);
	twh_slave slave (.scl, .sda, .nack, .sda_oe(s_oe), .last(got));

	initial
		forever #50 aclk = ~aclk;

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	function automatic logic [31:0] exp_st(input int k, input logic n);
		if (k == 0)
			return n ? TWH_ST_ADDR_NACK : TWH_ST_ADDR_ACK;
		return n ? TWH_ST_DATA_NACK : TWH_ST_DATA_ACK;
	endfunction : exp_st

	task automatic final_report;
		if (fail_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [31:0] x);
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= x;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		bready <= 1'b0;
		rr = bresp;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] x);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		rready <= 1'b0;
		x = rdata;
		rr = rresp;
	endtask : rd

	// Software waits by polling the flag, not on the interrupt.
	task automatic poll;
		logic [31:0] x = 32'h0;
		while (x[TWH_CTL_FLAG] !== 1'b1)
			rd(TWH_ADDR_CTRL, x);
	endtask : poll

	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			fail_count++;
			final_report();
		end
	end

	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(TWH_ADDR_STATUS, v);
		chk("status", TWH_ST_NONE, v);
		rd(4'h2, v);
		chk("rresp", 32'(TWH_RESP_SLVERR), 32'(rr));
		chk("rdata", 32'h0, v);
		wr(4'h2, 32'h0);
		chk("bresp", 32'(TWH_RESP_SLVERR), 32'(rr));
		for (t = 0; t < 2; t++)
		begin
			wr(TWH_ADDR_CPU, t ? 32'h0 : 32'h80);
			wr(TWH_ADDR_CTRL, 32'hA5);
			poll();
			rd(TWH_ADDR_STATUS, v);
			chk("start", TWH_ST_START, v & 32'hF8);
			chk("irq", t == 0, irq);
			chk("scl", 32'h1, scl_pin.oe);
			wr(TWH_ADDR_CTRL, 32'h25);
			rd(TWH_ADDR_CTRL, v);
			chk("flag", 32'h1, v[TWH_CTL_FLAG]);
			for (k = 0; k < 3; k++)
			begin
				d = lfsr_next(d);
				n = (k == 0 && t == 1) || (k == 2 && t == 0);
				nack <= n;
				wr(TWH_ADDR_DATA, {24'h0, d[7:0]});
				wr(TWH_ADDR_CTRL, 32'h85);
				poll();
				rd(TWH_ADDR_STATUS, v);
				chk("code", exp_st(k, n), v & 32'hF8);
				chk("byte", d[7:0], got);
			end
			if (t == 1)
			begin
				wr(TWH_ADDR_CTRL, 32'hA4);
				poll();
				rd(TWH_ADDR_STATUS, v);
				chk("rstart", TWH_ST_RSTART, v & 32'hF8);
			end
			wr(TWH_ADDR_CTRL, 32'h94);
			repeat (300) @(posedge aclk);
			rd(TWH_ADDR_CTRL, v);
			chk("stop", 32'h0, v[TWH_CTL_FLAG]);
			rd(TWH_ADDR_STATUS, v);
			chk("idle", TWH_ST_NONE, v);
		end
		final_report();
	end
endmodule : test_two_wire_host_handshake

bind twh_top twh_top_props props (.aclk, .aresetn, .awvalid, .awready,
	.wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid,
	.rready, .rdata, .rresp, .scl_pin, .sda_pin, .irq);
